// file: dbgcp_pkg.sv
// How it works
// - command byte first, replies high byte first
// - outside halt only a command subset runs
// - codes 00h/02h/03h read revision, status, counter
// - 04h loads bits 7:5 of next byte into control register
// - read protect: halt settable, never cleared
// - 05h returns the control register
// - 06h loads pc, dropped if blocked
// - 07h returns pc, or ffffh if blocked
// - 08h: address high, low, size, data; 0=256
// - register write outside halt changes nothing
// - read protect: only flash control registers written
// - 12h blocked reads and drops one byte
// - halt flag stops the processor fetching
// - breakpoint opcode with enable sets halt
// - breakpoint disabled runs as no-operation
// - reset bit restarts device, halted or running
// - clearing halt resumes program execution
// - runtime counter runs unhalted, saturates at ffffh
package dbgcp_pkg;

    // ------------------------------------------------------------
    // command codes
    // ------------------------------------------------------------
    localparam logic [7:0] CMD_READ_REV   = 8'h00;
    localparam logic [7:0] CMD_RESERVED   = 8'h01;
    localparam logic [7:0] CMD_READ_STAT  = 8'h02;
    localparam logic [7:0] CMD_READ_RTC   = 8'h03;
    localparam logic [7:0] CMD_WRITE_CTL  = 8'h04;
    localparam logic [7:0] CMD_READ_CTL   = 8'h05;
    localparam logic [7:0] CMD_WRITE_PC   = 8'h06;
    localparam logic [7:0] CMD_READ_PC    = 8'h07;
    localparam logic [7:0] CMD_WRITE_REG  = 8'h08;
    localparam logic [7:0] CMD_EXEC_OP    = 8'h12;

    // ------------------------------------------------------------
    // debug control register fields
    // ------------------------------------------------------------
    localparam int         CTL_HALT_BIT   = 7;
    localparam int         CTL_BREAKPOINT_ENABLE_BIT  = 6;
    localparam int         CTL_ACK_BIT    = 5;
    localparam int         CTL_RST_BIT    = 0;
    localparam logic [7:0] CTL_RESET      = 8'h00;
    localparam logic [7:0] CTL_STORE_MASK = 8'he0;

    // ------------------------------------------------------------
    // status register fields
    // ------------------------------------------------------------
    localparam int         STAT_HALT_BIT  = 7;
    localparam int         STAT_RP_BIT    = 6;

    // ------------------------------------------------------------
    // values and counts
    // ------------------------------------------------------------
    localparam logic [15:0] REVISION      = 16'h0a01; // arbitrary value
    localparam logic [15:0] PC_BLOCKED    = 16'hffff;
    localparam logic [15:0] RTC_MAX       = 16'hffff;
    localparam logic [15:0] RTC_RESET     = 16'h0000;
    localparam logic [8:0]  SIZE_ZERO_LEN = 9'h100;
    localparam logic [11:0] FLASH_CTL_LO  = 12'hff8;
    localparam logic [11:0] FLASH_CTL_HI  = 12'hfff;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_OPER = 2'b01,
        ST_SEND = 2'b10,
        ST_DATA = 2'b11
    } dbgcp_state_e;

endpackage

// file: dbgcp_runtime_counter.sv
`timescale 1ns/1ps
module dbgcp_runtime_counter (
    input  wire logic        clock,
    input  wire logic        srst,
    input  wire logic        run,
    output logic [15:0]      count_q
);

    typedef struct packed {
        logic        run_prev;
        logic [15:0] count;
    } dbgcp_rtc_s;

    dbgcp_rtc_s s_q;
    dbgcp_rtc_s s_d;

    // ------------------------------------------------------------
    // count between halts
    // ------------------------------------------------------------
    always_comb begin
        s_d          = s_q;
        s_d.run_prev = run;
        if (run && !s_q.run_prev) begin
            s_d.count = dbgcp_pkg::RTC_RESET;
        end else if (run && s_q.count != dbgcp_pkg::RTC_MAX) begin
            s_d.count = s_q.count + 16'h0001;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            s_q <= '{run_prev: 1'b0, count: dbgcp_pkg::RTC_RESET};
        end else begin
            s_q <= s_d;
        end
    end

    assign count_q = s_q.count;

endmodule

// file: dbgcp_command_port.sv
`timescale 1ns/1ps
module dbgcp_command_port (
    input  wire logic        clock,
    input  wire logic        srst,
    // byte stream from debug serial pin framer
    input  wire logic        rx_valid,
    input  wire logic [7:0]  rx_data,
    // byte stream toward framer
    input  wire logic        tx_ready,
    output logic             tx_valid,
    output logic [7:0]       tx_data,
    // option and processor side
    input  wire logic        read_protect_option,
    input  wire logic [15:0] pc_value,
    input  wire logic        brk_decoded,
    input  wire logic [2:0]  opcode_len,
    output logic             halt_flag,
    output logic             cpu_reset,
    output logic             pc_wr,
    output logic [15:0]      pc_wdata,
    output logic             reg_wr,
    output logic [11:0]      reg_addr,
    output logic [7:0]       reg_wdata,
    output logic             exec_valid,
    output logic [7:0]       exec_data,
    output logic [15:0]      runtime_count
);

    typedef struct packed {
        dbgcp_pkg::dbgcp_state_e st;
        logic [7:0]              cmd;
        logic [1:0]              idx;
        logic                    keep;
        logic [8:0]              left;
        logic [11:0]             addr;
        logic [7:0]              pc_hi;
        logic [15:0]             resp;
        logic [1:0]              nresp;
        logic [7:0]              ctl;
        logic                    tx_valid;
        logic [7:0]              tx_data;
        logic                    cpu_reset;
        logic                    pc_wr;
        logic [15:0]             pc_wdata;
        logic                    reg_wr;
        logic [11:0]             reg_addr;
        logic [7:0]              reg_wdata;
        logic                    exec_valid;
        logic [7:0]              exec_data;
    } dbgcp_state_s;

    dbgcp_state_s s_q;
    dbgcp_state_s s_d;

    logic         halted;
    logic         rp;
    logic [7:0]   status;
    logic [15:0]  rtc;
    logic [7:0]   ctl_new;
    logic         flash_ctl_hit;

    assign halted        = s_q.ctl[dbgcp_pkg::CTL_HALT_BIT];
    assign rp            = read_protect_option;
    assign flash_ctl_hit = (s_q.addr >= dbgcp_pkg::FLASH_CTL_LO) && (s_q.addr <= dbgcp_pkg::FLASH_CTL_HI);

    // ------------------------------------------------------------
    // status byte and control write value
    // ------------------------------------------------------------
    always_comb begin
        status                           = 8'h00;
        status[dbgcp_pkg::STAT_HALT_BIT] = halted;
        status[dbgcp_pkg::STAT_RP_BIT]   = rp;
    end

    always_comb begin
        ctl_new = rx_data & dbgcp_pkg::CTL_STORE_MASK;
        if (rp && halted) begin
            ctl_new[dbgcp_pkg::CTL_HALT_BIT] = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // runtime counter
    // ------------------------------------------------------------
    dbgcp_runtime_counter u_rtc (
        .clock   (clock),
        .srst    (srst),
        .run     (!halted),
        .count_q (rtc)
    );

    // ------------------------------------------------------------
    // command interpreter
    // ------------------------------------------------------------
    always_comb begin
        s_d            = s_q;
        s_d.tx_valid   = 1'b0;
        s_d.cpu_reset  = 1'b0;
        s_d.pc_wr      = 1'b0;
        s_d.reg_wr     = 1'b0;
        s_d.exec_valid = 1'b0;

        case (s_q.st)
            dbgcp_pkg::ST_IDLE: begin
                if (rx_valid) begin
                    s_d.cmd  = rx_data;
                    s_d.idx  = 2'b00;
                    s_d.keep = 1'b0;
                    case (rx_data)
                        dbgcp_pkg::CMD_READ_REV: begin
                            s_d.resp  = dbgcp_pkg::REVISION;
                            s_d.nresp = 2'd2;
                            s_d.st    = dbgcp_pkg::ST_SEND;
                        end
                        dbgcp_pkg::CMD_READ_STAT: begin
                            s_d.resp  = {status, 8'h00};
                            s_d.nresp = 2'd1;
                            s_d.st    = dbgcp_pkg::ST_SEND;
                        end
                        dbgcp_pkg::CMD_READ_RTC: begin
                            if (halted) begin
                                s_d.resp  = rtc;
                                s_d.nresp = 2'd2;
                                s_d.st    = dbgcp_pkg::ST_SEND;
                            end
                        end
                        dbgcp_pkg::CMD_WRITE_CTL: begin
                            s_d.st = dbgcp_pkg::ST_OPER;
                        end
                        dbgcp_pkg::CMD_READ_CTL: begin
                            s_d.resp  = {s_q.ctl, 8'h00};
                            s_d.nresp = 2'd1;
                            s_d.st    = dbgcp_pkg::ST_SEND;
                        end
                        dbgcp_pkg::CMD_WRITE_PC: begin
                            s_d.keep = halted && !rp;
                            s_d.st   = dbgcp_pkg::ST_OPER;
                        end
                        dbgcp_pkg::CMD_READ_PC: begin
                            s_d.resp  = (halted && !rp) ? pc_value : dbgcp_pkg::PC_BLOCKED;
                            s_d.nresp = 2'd2;
                            s_d.st    = dbgcp_pkg::ST_SEND;
                        end
                        dbgcp_pkg::CMD_WRITE_REG: begin
                            s_d.keep = halted;
                            s_d.st   = dbgcp_pkg::ST_OPER;
                        end
                        dbgcp_pkg::CMD_EXEC_OP: begin
                            s_d.keep = halted && !rp;
                            s_d.st   = dbgcp_pkg::ST_OPER;
                        end
                        default: begin
                            s_d.st = dbgcp_pkg::ST_IDLE;
                        end
                    endcase
                end
            end

            dbgcp_pkg::ST_OPER: begin
                if (rx_valid) begin
                    s_d.idx = s_q.idx + 2'b01;
                    case (s_q.cmd)
                        dbgcp_pkg::CMD_WRITE_CTL: begin
                            s_d.ctl       = ctl_new;
                            s_d.cpu_reset = rx_data[dbgcp_pkg::CTL_RST_BIT];
                            s_d.st        = dbgcp_pkg::ST_IDLE;
                        end
                        dbgcp_pkg::CMD_WRITE_PC: begin
                            if (s_q.idx == 2'b00) begin
                                s_d.pc_hi = rx_data;
                            end else begin
                                s_d.pc_wr    = s_q.keep;
                                s_d.pc_wdata = {s_q.pc_hi, rx_data};
                                s_d.st       = dbgcp_pkg::ST_IDLE;
                            end
                        end
                        dbgcp_pkg::CMD_WRITE_REG: begin
                            case (s_q.idx)
                                2'b00: begin
                                    s_d.addr[11:8] = rx_data[3:0];
                                end
                                2'b01: begin
                                    s_d.addr[7:0] = rx_data;
                                end
                                default: begin
                                    s_d.left = (rx_data == 8'h00) ? dbgcp_pkg::SIZE_ZERO_LEN
                                                                   : {1'b0, rx_data};
                                    s_d.st   = dbgcp_pkg::ST_DATA;
                                end
                            endcase
                        end
                        default: begin
                            if (s_q.keep) begin
                                s_d.exec_valid = 1'b1;
                                s_d.exec_data  = rx_data;
                                s_d.left       = {6'h00, opcode_len} - 9'h001;
                                if (opcode_len > 3'd1) begin
                                    s_d.st = dbgcp_pkg::ST_DATA;
                                end else begin
                                    s_d.st = dbgcp_pkg::ST_IDLE;
                                end
                            end else begin
                                s_d.st = dbgcp_pkg::ST_IDLE;
                            end
                        end
                    endcase
                end
            end

            dbgcp_pkg::ST_DATA: begin
                if (rx_valid) begin
                    s_d.left = s_q.left - 9'h001;
                    if (s_q.left == 9'h001) begin
                        s_d.st = dbgcp_pkg::ST_IDLE;
                    end
                    if (s_q.cmd == dbgcp_pkg::CMD_WRITE_REG) begin
                        s_d.reg_wr    = s_q.keep && (!rp || flash_ctl_hit);
                        s_d.reg_addr  = s_q.addr;
                        s_d.reg_wdata = rx_data;
                        s_d.addr      = s_q.addr + 12'h001;
                    end else begin
                        s_d.exec_valid = 1'b1;
                        s_d.exec_data  = rx_data;
                    end
                end
            end

            dbgcp_pkg::ST_SEND: begin
                if (tx_ready && !s_q.tx_valid) begin
                    s_d.tx_valid = 1'b1;
                    s_d.tx_data  = s_q.resp[15:8];
                    s_d.resp     = {s_q.resp[7:0], 8'h00};
                    s_d.nresp    = s_q.nresp - 2'd1;
                    if (s_q.nresp == 2'd1) begin
                        s_d.st = dbgcp_pkg::ST_IDLE;
                    end
                end
            end

            default: begin
                s_d.st = dbgcp_pkg::ST_IDLE;
            end
        endcase

        // breakpoint sets halt; wins over a control write in the same cycle
        if (brk_decoded && s_q.ctl[dbgcp_pkg::CTL_BREAKPOINT_ENABLE_BIT]) begin
            s_d.ctl[dbgcp_pkg::CTL_HALT_BIT] = 1'b1;
        end
        // else the breakpoint opcode just retires as a no-operation
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            s_q <= '{st: dbgcp_pkg::ST_IDLE, ctl: dbgcp_pkg::CTL_RESET, default: '0};
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------
    // outputs, all from flops
    // ------------------------------------------------------------
    assign halt_flag     = s_q.ctl[dbgcp_pkg::CTL_HALT_BIT];
    assign cpu_reset     = s_q.cpu_reset;
    assign tx_valid      = s_q.tx_valid;
    assign tx_data       = s_q.tx_data;
    assign pc_wr         = s_q.pc_wr;
    assign pc_wdata      = s_q.pc_wdata;
    assign reg_wr        = s_q.reg_wr;
    assign reg_addr      = s_q.reg_addr;
    assign reg_wdata     = s_q.reg_wdata;
    assign exec_valid    = s_q.exec_valid;
    assign exec_data     = s_q.exec_data;
    assign runtime_count = rtc;

endmodule

// file: dbgcp_command_port_properties.sv
`timescale 1ns/1ps
module dbgcp_command_port_chk (
    input  wire logic        clock,
    input  wire logic        srst,
    input  wire logic        rx_valid,
    input  wire logic        tx_ready,
    input  wire logic        tx_valid,
    input  wire logic        read_protect_option,
    input  wire logic        brk_decoded,
    input  wire logic        halt_flag,
    input  wire logic        cpu_reset,
    input  wire logic        pc_wr,
    input  wire logic        reg_wr,
    input  wire logic [11:0] reg_addr,
    input  wire logic        exec_valid,
    input  wire logic [15:0] runtime_count
);
    default clocking @(posedge clock); endclocking
    default disable iff (srst);
    // ------------------------------------------------------------
    // reply stream
    // ------------------------------------------------------------
    reply_ready_a: assert property (tx_valid |-> $past(tx_ready))
        else $error("reply byte sent without ready");
    reply_spacing_a: assert property (tx_valid |=> !tx_valid)
        else $error("reply bytes closer than two cycles");
    // ------------------------------------------------------------
    // gating by halt and read protect
    // ------------------------------------------------------------
    pc_gate_a: assert property (pc_wr |-> halt_flag && !read_protect_option)
        else $error("pc written while blocked");
    reg_gate_a: assert property (reg_wr |-> halt_flag && (!read_protect_option || reg_addr >= 12'hff8))
        else $error("register written while blocked");
    exec_gate_a: assert property (exec_valid |-> halt_flag && !read_protect_option)
        else $error("opcode forwarded while blocked");
    halt_lock_a: assert property (read_protect_option && halt_flag |=> halt_flag)
        else $error("halt cleared under read protect");
    halt_cause_a: assert property ($rose(halt_flag) |-> $past(rx_valid) || $past(rx_valid, 2)
                                   || $past(brk_decoded) || $past(brk_decoded, 2))
        else $error("halt set without write or breakpoint");
    restart_pulse_a: assert property (cpu_reset |=> !cpu_reset)
        else $error("restart pulse longer than one cycle");
    // ------------------------------------------------------------
    // runtime counter
    // ------------------------------------------------------------
    count_hold_a: assert property (halt_flag && $past(halt_flag) && $past(halt_flag, 2)
                                   |-> $stable(runtime_count))
        else $error("counter moved while halted");
    count_run_a: assert property (!halt_flag && !$past(halt_flag) && !$past(halt_flag, 2) && !$past(halt_flag, 3)
                                  && !$past(srst) && !$past(srst, 2) && $past(runtime_count) != 16'hffff
                                  |-> runtime_count == $past(runtime_count) + 16'h0001)
        else $error("counter did not advance while running");
endmodule
bind dbgcp_command_port dbgcp_command_port_chk u_dbgcp_command_port_chk (.clock, .srst, .rx_valid, .tx_ready,
    .tx_valid, .read_protect_option, .brk_decoded, .halt_flag, .cpu_reset, .pc_wr, .reg_wr, .reg_addr,
    .exec_valid, .runtime_count);

// file: dbgcp_host_model.sv
`timescale 1ns/1ps
module dbgcp_host_model (
    input  wire logic       clock,
    input  wire logic       slow,
    output logic            rx_valid,
    output logic [7:0]      rx_data,
    output logic            tx_ready,
    input  wire logic       tx_valid,
    input  wire logic [7:0] tx_data
);
    logic [7:0] got[$];
    logic [1:0] tick = 2'h0;
    initial begin
        rx_valid = 1'b0;
        rx_data = 8'h00;
    end
    // slow host takes a byte only half the time
    always @(posedge clock) tick <= tick + 2'h1;
    assign tx_ready = !slow || tick[1];
    // ready was promised at the edge before the byte shows, so every byte is kept
    always @(posedge clock) begin
        if (tx_valid)
            got.push_back(tx_data);
    end
    // command byte, then operands, one per cycle
    task automatic send(input logic [7:0] b[$]);
        foreach (b[i]) begin
            @(posedge clock);
            #1;
            rx_valid = 1'b1;
            rx_data = b[i];
        end
        @(posedge clock);
        #1;
        rx_valid = 1'b0;
        rx_data = ~rx_data;
    endtask
endmodule

// file: dbgcp_command_port_tb.sv
`timescale 1ns/1ps
module dbgcp_command_port_tb;
    logic        clock, srst, slow, read_protect_option, brk_decoded;
    logic        rx_valid, tx_ready, tx_valid, halt_flag, cpu_reset, pc_wr, reg_wr, exec_valid;
    logic [2:0]  opcode_len;
    logic [7:0]  rx_data, tx_data, reg_wdata, exec_data;
    logic [11:0] reg_addr;
    logic [15:0] pc_value, runtime_count, pc_wdata, r, t, base;
    logic [15:0] n_pc = '0, n_reg = '0, n_exec = '0, n_rst = '0, last_pc, last_reg, last_exec;
    logic [7:0]  q[$];
    int          mismatches = 0, checks = 0, cycles = 0;

    dbgcp_command_port u_dbgcp_command_port (.clock, .srst, .rx_valid, .rx_data, .tx_ready, .tx_valid, .tx_data,
        .read_protect_option, .pc_value, .brk_decoded, .opcode_len, .halt_flag, .cpu_reset, .pc_wr, .pc_wdata,
        .reg_wr, .reg_addr, .reg_wdata, .exec_valid, .exec_data, .runtime_count);
    dbgcp_host_model u_dbgcp_host_model (.clock, .slow, .rx_valid, .rx_data, .tx_ready, .tx_valid, .tx_data);

    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end
    // ------------------------------------------------------------
    // processor side monitor and hang guard
    // ------------------------------------------------------------
    always @(posedge clock) begin
        cycles++;
        n_pc <= n_pc + 16'(pc_wr);
        n_reg <= n_reg + 16'(reg_wr);
        n_exec <= n_exec + 16'(exec_valid);
        n_rst <= n_rst + 16'(cpu_reset);
        if (pc_wr) last_pc <= pc_wdata;
        if (reg_wr) last_reg <= {reg_addr[7:0], reg_wdata};
        if (exec_valid) last_exec <= {8'h00, exec_data};
        if (cycles == 20000) begin
            mismatches++;
            results();
        end
    end
    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic xfer(input logic [7:0] b[$], input int n);
        int k;
        u_dbgcp_host_model.got.delete();
        u_dbgcp_host_model.send(b);
        for (k = 0; k < 40 && u_dbgcp_host_model.got.size() < n; k++)
            @(posedge clock);
        repeat (6) @(posedge clock);
        #1;
        chk(16'(u_dbgcp_host_model.got.size()), 16'(n));
        r = 16'h0000;
        foreach (u_dbgcp_host_model.got[i]) r = {r[7:0], u_dbgcp_host_model.got[i]};
    endtask
    task automatic brk_pulse();
        brk_decoded = 1'b1;
        @(posedge clock);
        #1;
        brk_decoded = 1'b0;
        repeat (3) @(posedge clock);
        #1;
    endtask
    task automatic results();
        $display("mismatches %0d checks %0d", mismatches, checks);
        if (mismatches == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // ------------------------------------------------------------
    // sequence
    // ------------------------------------------------------------
    initial begin
        srst = 1'b1;
        slow = 1'b0;
        read_protect_option = 1'b0;
        brk_decoded = 1'b0;
        opcode_len = 3'h3;
        pc_value = 16'habcd;
        repeat (2) @(posedge clock);
        #1;
        srst = 1'b0;
        xfer('{8'h05}, 1); chk(r, 16'h0000);
        xfer('{8'h00}, 2); chk(r, dbgcp_pkg::REVISION);
        xfer('{8'h02}, 1); chk(r, 16'h0000);
        xfer('{8'h03}, 0);
        xfer('{8'h07}, 2); chk(r, 16'hffff);
        xfer('{8'h06, 8'h12, 8'h34}, 0); chk(n_pc, 16'h0000);
        xfer('{8'h08, 8'h00, 8'h20, 8'h01, 8'h55}, 0); chk(n_reg, 16'h0000);
        xfer('{8'h12, 8'h00, 8'h02}, 1); chk(n_exec, 16'h0000);
        xfer('{8'h01, 8'h02}, 1);
        brk_pulse(); chk({15'h0, halt_flag}, 16'h0000);
        t = runtime_count;
        repeat (10) @(posedge clock);
        #1;
        chk(runtime_count - t, 16'h000a);
        xfer('{8'h04, 8'hc0}, 0); chk({15'h0, halt_flag}, 16'h0001);
        xfer('{8'h05}, 1); chk(r, 16'h00c0);
        xfer('{8'h02}, 1); chk(r, 16'h0080);
        t = runtime_count;
        xfer('{8'h03}, 2); chk(r, t);
        xfer('{8'h06, 8'h12, 8'h34}, 0); chk(last_pc, 16'h1234);
        slow = 1'b1;
        xfer('{8'h07}, 2); chk(r, 16'habcd);
        slow = 1'b0;
        xfer('{8'h08, 8'h01, 8'h23, 8'h02, 8'h55, 8'h66}, 0); chk(last_reg, 16'h2466);
        chk(n_reg, 16'h0002);
        q = '{8'h08, 8'h00, 8'h00, 8'h00};
        for (int i = 0; i < 256; i++)
            q.push_back(8'(i));
        base = n_reg;
        xfer(q, 0); chk(n_reg - base, 16'h0100);
        xfer('{8'h12, 8'ha1, 8'ha2, 8'ha3, 8'h02}, 1); chk(n_exec, 16'h0003);
        chk(last_exec, 16'h00a3);
        xfer('{8'h04, 8'h40}, 0); chk({15'h0, halt_flag}, 16'h0000);
        brk_pulse(); chk({15'h0, halt_flag}, 16'h0001);
        xfer('{8'h04, 8'h81}, 0); chk(n_rst, 16'h0001);
        chk({15'h0, halt_flag}, 16'h0001);
        xfer('{8'h04, 8'h01}, 0); chk(n_rst, 16'h0002);
        chk({15'h0, halt_flag}, 16'h0000);
        read_protect_option = 1'b1;
        xfer('{8'h04, 8'h80}, 0); chk({15'h0, halt_flag}, 16'h0001);
        xfer('{8'h04, 8'h00}, 0); chk({15'h0, halt_flag}, 16'h0001);
        xfer('{8'h02}, 1); chk(r, 16'h00c0);
        xfer('{8'h07}, 2); chk(r, 16'hffff);
        xfer('{8'h06, 8'h55, 8'h66}, 0); chk(n_pc, 16'h0001);
        base = n_reg;
        xfer('{8'h08, 8'h0f, 8'hf8, 8'h02, 8'h11, 8'h22}, 0); chk(n_reg - base, 16'h0002);
        xfer('{8'h08, 8'h00, 8'h10, 8'h01, 8'h33}, 0); chk(n_reg - base, 16'h0002);
        xfer('{8'h12, 8'h00, 8'h02}, 1); chk(n_exec, 16'h0003);
        srst = 1'b1;
        repeat (2) @(posedge clock);
        #1;
        srst = 1'b0;
        chk({15'h0, halt_flag}, 16'h0000);
        results();
    end
endmodule
